// ===== logic/fault_supervisor_pkg.sv
// Shared constants for the converter fault supervisor
package fault_supervisor_pkg;

    // Register offsets, byte addresses of aligned 32-bit words
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_THRESH = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN = 8'h14;

    // Protection index, shared by fault, latch and event bits
    localparam int P_OCP = 0;
    localparam int P_OVT = 1;
    localparam int P_UVP = 2;
    localparam int P_OTP = 3;
    localparam int P_TRK = 4;
    localparam int NPROT = 5;
    // Extra qualified conditions
    localparam int Q_WARN = 5;
    localparam int Q_PG = 6;
    localparam int NQUAL = 7;

    // Control register layout
    localparam int CTRL_TRK_EN = 5;
    localparam int CTRL_FCLR = 6;
    localparam logic [4:0] LATCH_RST = 5'h00;
    localparam logic TRK_EN_RST = 1'b0;

    // Threshold register layout and reset steps
    localparam int TH_OCP_LSB = 0;
    localparam int TH_OVT_LSB = 4;
    localparam int TH_UVP_LSB = 6;
    localparam int TH_PG_SEL = 8;
    localparam logic [3:0] OCP_STEP_RST = 4'ha;
    localparam logic [1:0] OVT_STEP_RST = 2'h2;
    localparam logic [1:0] UVP_STEP_RST = 2'h0;
    localparam logic PG_SEL_RST = 1'b0;

    // Threshold figures in percent of rated current or setpoint
    localparam logic [7:0] OCP_BASE = 8'd60;
    localparam logic [7:0] OCP_INC = 8'd11;
    localparam logic [3:0] OCP_MAX_STEP = 4'ha;
    localparam logic [7:0] OVT_BASE = 8'd110;
    localparam logic [7:0] OVT_INC = 8'd10;
    localparam logic [1:0] OVT_MAX_STEP = 2'h2;
    localparam logic [7:0] UVP_BASE = 8'd75;
    localparam logic [7:0] UVP_INC = 8'd5;
    localparam logic [1:0] UVP_MAX_STEP = 2'h2;
    localparam logic [7:0] PG_LOW_A = 8'd90;
    localparam logic [7:0] PG_LOW_B = 8'd95;
    localparam logic [7:0] PG_HIGH = 8'd110;
    localparam logic [7:0] PCT_FULL = 8'd100;

    // Absolute figures: millivolts and degrees C
    localparam logic [15:0] OVT_FLOOR_MV = 16'd1000;
    localparam logic [15:0] TRK_BAND_MV = 16'd250;
    localparam logic signed [9:0] OTP_TRIP_C = 10'sd130;
    localparam logic signed [9:0] OTP_RESTART_C = 10'sd120;
    localparam logic signed [9:0] WARN_SET_C = 10'sd120;
    localparam logic signed [9:0] WARN_HYST_C = 10'sd3;

    // Timing: clock period, qualification delay and retry period
    localparam int CLK_NS = 10;
    localparam int QUAL_NS = 6000;
    localparam int QUAL_CYC = QUAL_NS / CLK_NS;
    localparam int RETRY_MS = 130;
    localparam int RETRY_CYC = RETRY_MS * (1000000 / CLK_NS);

endpackage : fault_supervisor_pkg

// ===== logic/settle_filter.sv
// Output follows its input once the input has differed for DELAY cycles
`timescale 1ns/1ps
module settle_filter #(
    parameter int DELAY = 600
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Raw condition and qualified result
    input wire logic in_i,
    output logic out_o
);
    logic [15:0] cnt_reg;

    // Count while input disagrees, adopt it when the count runs out
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 16'h0000;
            out_o <= 1'b0;
        end else if (ce_i) begin
            if (in_i == out_o) begin
                cnt_reg <= 16'h0000;
            end else if (cnt_reg == 16'(DELAY - 1)) begin
                cnt_reg <= 16'h0000;
                out_o <= in_i; // R06
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    property p_settle;
        @(posedge clk_i) disable iff (!rst_n_i)
        (out_o != $past(out_o)) |-> $past(cnt_reg) == 16'(DELAY - 1);
    endproperty
    a_settle: assert property (p_settle) else $error("Filter moved early"); // R13

endmodule : settle_filter

// ===== logic/retry_timer.sv
// One-shot retry period timer with a done pulse
`timescale 1ns/1ps
module retry_timer #(
    parameter int COUNT = 13000000
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Start request, running level and expiry pulse
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    logic [31:0] cnt_reg;

    // Run for COUNT cycles from the start, then pulse done
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 32'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (!busy_o) begin
                if (start_i) begin
                    busy_o <= 1'b1;
                    cnt_reg <= 32'h0;
                end
            end else if (cnt_reg == 32'(COUNT - 1)) begin
                busy_o <= 1'b0;
                done_o <= 1'b1; // R01
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end

    property p_done_timed;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(done_o) |-> $past(cnt_reg) == 32'(COUNT - 1);
    endproperty
    a_done_timed: assert property (p_done_timed) else $error("Retry ended early"); // R15

endmodule : retry_timer

// ===== logic/fault_supervisor.sv
// Converter fault supervisor: thresholds, trip, retry, warning, power good
// How it works
// R01: Each of OC, OV, UV latches or retries turn-on every 130 ms.
// R02: Overcurrent level 60..170 percent of rated current in 11 steps, default 170.
// R03: Overvoltage level 110..130 percent of setpoint in 10 percent steps, default 130.
// R04: Overvoltage level never falls below 1.0 V.
// R05: Undervoltage level 75..85 percent in 5 percent steps, default 75.
// R06: OV, UV, OT and tracking trips turn the converter off after 6 us.
// R07: Shut down at 130 C rising, restart allowed only at 120 C.
// R08: Tracking armed only on ramp-up, trips beyond 250 mV either way.
// R09: Tracking off after reset; latching or 130 ms retry when on.
// R10: Warning flag set at 120 C, cleared 3 C lower, no shutdown.
// R11: Warning flag rises 6 us after its threshold is passed.
// R12: Power good high inside window 90 or 95 up to 110 percent.
// R13: Power good changes 6 us after a window boundary is crossed.
// R14: Latched trip keeps converter off until software clear or reset.
// R15: Digitized samples compared each cycle; retry counted in clock cycles.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module fault_supervisor #(
    parameter int RETRY_CYCLES = fault_supervisor_pkg::RETRY_CYC,
    parameter int QUAL_CYCLES = fault_supervisor_pkg::QUAL_CYC
) (
    // Clock, reset and clock enable
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // Measurement samples, millivolts, milliamps, degrees C
    input wire logic [15:0] VOUT_I,
    input wire logic [15:0] VSET_I,
    input wire logic [15:0] VTRACK_I,
    input wire logic [15:0] IOUT_I,
    input wire logic [15:0] IRATED_I,
    input wire logic signed [9:0] TEMP_I,
    input wire logic RAMP_UP_I,
    // Converter command, power good and interrupt
    output logic CONV_OFF_O,
    output logic OUTPUT_IN_WINDOW_FLAG_O,
    output logic IRQ_O
);
    localparam int NEV = fault_supervisor_pkg::NQUAL;

    // Scale a sample by a percentage figure
    function automatic logic [24:0] pct_of(input logic [15:0] v, input logic [7:0] p);
        pct_of = 25'(v) * 25'(p);
    endfunction : pct_of

    // Clamp a step code to its top step
    function automatic logic [3:0] clamp_step(input logic [3:0] s, input logic [3:0] top);
        clamp_step = (s > top) ? top : s;
    endfunction : clamp_step

    logic [4:0] latch_reg;
    logic trk_en_reg;
    logic [3:0] ocp_step_reg;
    logic [1:0] ovt_step_reg;
    logic [1:0] uvp_step_reg;
    logic pg_sel_reg;
    logic [NEV-1:0] irq_stat_reg;
    logic [NEV-1:0] irq_en_reg;
    logic [4:0] fault_reg;
    logic [4:0] fault_next;
    logic [NEV-1:0] raw;
    logic [NEV-1:0] qual;
    logic [NEV-1:0] event_set;
    logic pg_prev_reg;
    logic warn_prev_reg;
    logic sw_clear;
    logic retry_start;
    logic retry_busy;
    logic retry_done;
    logic [7:0] ocp_pct;
    logic [7:0] ovt_pct;
    logic [7:0] uvp_pct;
    logic [7:0] pg_low_pct;
    logic [24:0] vout_x100;
    logic [24:0] ovt_lvl;
    logic [24:0] ovt_floor;
    logic [15:0] trk_diff;
    logic [31:0] status_word;

    // Software register writes
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            latch_reg <= fault_supervisor_pkg::LATCH_RST;
            trk_en_reg <= fault_supervisor_pkg::TRK_EN_RST; // R09
            ocp_step_reg <= fault_supervisor_pkg::OCP_STEP_RST; // R02
            ovt_step_reg <= fault_supervisor_pkg::OVT_STEP_RST; // R03
            uvp_step_reg <= fault_supervisor_pkg::UVP_STEP_RST; // R05
            pg_sel_reg <= fault_supervisor_pkg::PG_SEL_RST;
            irq_en_reg <= '0;
        end else if (CE_I && WR_I) begin
            case (ADDR_I)
                fault_supervisor_pkg::OFF_CTRL: begin
                    latch_reg <= WDATA_I[4:0]; // R01
                    trk_en_reg <= WDATA_I[fault_supervisor_pkg::CTRL_TRK_EN];
                end
                fault_supervisor_pkg::OFF_THRESH: begin
                    ocp_step_reg <= clamp_step(WDATA_I[3:0], fault_supervisor_pkg::OCP_MAX_STEP);
                    ovt_step_reg <= 2'(clamp_step({2'b00, WDATA_I[5:4]},
                        {2'b00, fault_supervisor_pkg::OVT_MAX_STEP}));
                    uvp_step_reg <= 2'(clamp_step({2'b00, WDATA_I[7:6]},
                        {2'b00, fault_supervisor_pkg::UVP_MAX_STEP}));
                    pg_sel_reg <= WDATA_I[fault_supervisor_pkg::TH_PG_SEL];
                end
                fault_supervisor_pkg::OFF_IRQ_EN: irq_en_reg <= WDATA_I[NEV-1:0];
                default: ;
            endcase
        end
    end

    // Fault clear is a write-one action, not stored
    assign sw_clear = WR_I && ADDR_I == fault_supervisor_pkg::OFF_CTRL
        && WDATA_I[fault_supervisor_pkg::CTRL_FCLR]; // R14

    // Percent figures from the step codes
    assign ocp_pct = fault_supervisor_pkg::OCP_BASE
        + 8'(fault_supervisor_pkg::OCP_INC * {4'h0, ocp_step_reg}); // R02
    assign ovt_pct = fault_supervisor_pkg::OVT_BASE
        + 8'(fault_supervisor_pkg::OVT_INC * {6'h00, ovt_step_reg}); // R03
    assign uvp_pct = fault_supervisor_pkg::UVP_BASE
        + 8'(fault_supervisor_pkg::UVP_INC * {6'h00, uvp_step_reg}); // R05
    assign pg_low_pct = pg_sel_reg ? fault_supervisor_pkg::PG_LOW_B
        : fault_supervisor_pkg::PG_LOW_A;

    // Sample comparisons scaled by one hundred, except the tracking difference in millivolts
    assign vout_x100 = pct_of(VOUT_I, fault_supervisor_pkg::PCT_FULL); // R15
    assign ovt_floor = pct_of(fault_supervisor_pkg::OVT_FLOOR_MV, fault_supervisor_pkg::PCT_FULL);
    assign ovt_lvl = (pct_of(VSET_I, ovt_pct) < ovt_floor) ? ovt_floor
        : pct_of(VSET_I, ovt_pct); // R04
    assign trk_diff = (VOUT_I > VTRACK_I) ? VOUT_I - VTRACK_I : VTRACK_I - VOUT_I;

    // Raw conditions; temperature ones hold between their two levels
    always_comb begin
        raw = '0;
        raw[fault_supervisor_pkg::P_OCP] = pct_of(IOUT_I, fault_supervisor_pkg::PCT_FULL)
            > pct_of(IRATED_I, ocp_pct); // R02
        raw[fault_supervisor_pkg::P_OVT] = vout_x100 > ovt_lvl; // R03
        // Undervoltage watched only while running and past the ramp
        raw[fault_supervisor_pkg::P_UVP] = !CONV_OFF_O && !RAMP_UP_I
            && vout_x100 < pct_of(VSET_I, uvp_pct); // R05
        if (TEMP_I >= fault_supervisor_pkg::OTP_TRIP_C) begin
            raw[fault_supervisor_pkg::P_OTP] = 1'b1; // R07
        end else if (TEMP_I <= fault_supervisor_pkg::OTP_RESTART_C) begin
            raw[fault_supervisor_pkg::P_OTP] = 1'b0; // R07
        end else begin
            raw[fault_supervisor_pkg::P_OTP] = qual[fault_supervisor_pkg::P_OTP];
        end
        raw[fault_supervisor_pkg::P_TRK] = trk_en_reg && RAMP_UP_I
            && trk_diff > fault_supervisor_pkg::TRK_BAND_MV; // R08
        if (TEMP_I >= fault_supervisor_pkg::WARN_SET_C) begin
            raw[fault_supervisor_pkg::Q_WARN] = 1'b1; // R10
        end else if (TEMP_I <= fault_supervisor_pkg::WARN_SET_C
                - fault_supervisor_pkg::WARN_HYST_C) begin
            raw[fault_supervisor_pkg::Q_WARN] = 1'b0; // R10
        end else begin
            raw[fault_supervisor_pkg::Q_WARN] = qual[fault_supervisor_pkg::Q_WARN];
        end
        raw[fault_supervisor_pkg::Q_PG] = vout_x100 >= pct_of(VSET_I, pg_low_pct)
            && vout_x100 <= pct_of(VSET_I, fault_supervisor_pkg::PG_HIGH); // R12
    end

    // One delay filter for each condition
    genvar gi;
    generate
        for (gi = 0; gi < NEV; gi++) begin : g_qual
            settle_filter #(
                .DELAY(QUAL_CYCLES) // R11
            ) u_filter (
                .clk_i(MCLK_I),
                .rst_n_i(RSTN_I),
                .ce_i(CE_I),
                .in_i(raw[gi]),
                .out_o(qual[gi])
            );
        end
    endgenerate

    // Trip flags: set wins over both clears
    always_comb begin
        for (int k = 0; k < fault_supervisor_pkg::NPROT; k++) begin
            if (k == fault_supervisor_pkg::P_OTP) begin
                // Cooling releases the flag; latching mode also needs software
                fault_next[k] = qual[k] || (fault_reg[k]
                    && (latch_reg[k] && !sw_clear)); // R07
            end else begin
                fault_next[k] = qual[k] || (fault_reg[k]
                    && !sw_clear && !(retry_done && !latch_reg[k])); // R14
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            fault_reg <= '0;
        end else if (CE_I) begin
            fault_reg <= fault_next; // R06
        end
    end

    // Retry period starts while a retrying trip is pending, but not on the done pulse,
    // whose flag is still set in that cycle and would start a spurious second period
    assign retry_start = |(fault_reg & ~latch_reg
        & ~(5'h01 << fault_supervisor_pkg::P_OTP)) && !retry_done; // R09

    retry_timer #(
        .COUNT(RETRY_CYCLES)
    ) u_retry (
        .clk_i(MCLK_I),
        .rst_n_i(RSTN_I),
        .ce_i(CE_I),
        .start_i(retry_start),
        .busy_o(retry_busy),
        .done_o(retry_done)
    );

    // Converter command and power good outputs
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            CONV_OFF_O <= 1'b0;
            OUTPUT_IN_WINDOW_FLAG_O <= 1'b0;
        end else if (CE_I) begin
            CONV_OFF_O <= |fault_reg; // R14
            OUTPUT_IN_WINDOW_FLAG_O <= qual[fault_supervisor_pkg::Q_PG]; // R13
        end
    end

    // Edge history for interrupt events
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            pg_prev_reg <= 1'b0;
            warn_prev_reg <= 1'b0;
        end else if (CE_I) begin
            pg_prev_reg <= qual[fault_supervisor_pkg::Q_PG];
            warn_prev_reg <= qual[fault_supervisor_pkg::Q_WARN];
        end
    end

    assign event_set = {qual[fault_supervisor_pkg::Q_PG] ^ pg_prev_reg,
        qual[fault_supervisor_pkg::Q_WARN] & ~warn_prev_reg,
        fault_next & ~fault_reg};

    // Sticky interrupt status, new events win over a clear
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            irq_stat_reg <= '0;
        end else if (CE_I) begin
            if (WR_I && ADDR_I == fault_supervisor_pkg::OFF_IRQ_CLR) begin
                irq_stat_reg <= (irq_stat_reg & ~WDATA_I[NEV-1:0]) | event_set;
            end else begin
                irq_stat_reg <= irq_stat_reg | event_set;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            IRQ_O <= 1'b0;
        end else if (CE_I) begin
            IRQ_O <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // Live status word
    assign status_word = {23'h0, retry_busy, qual[fault_supervisor_pkg::Q_PG],
        qual[fault_supervisor_pkg::Q_WARN], CONV_OFF_O, fault_reg}; // R10

    // Read data one cycle after the read strobe
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            RDATA_O <= 32'h0;
        end else if (CE_I) begin
            if (RD_I) begin
                case (ADDR_I)
                    fault_supervisor_pkg::OFF_CTRL:
                        RDATA_O <= {25'h0, 1'b0, trk_en_reg, latch_reg};
                    fault_supervisor_pkg::OFF_THRESH:
                        RDATA_O <= {23'h0, pg_sel_reg, uvp_step_reg, ovt_step_reg, ocp_step_reg};
                    fault_supervisor_pkg::OFF_STATUS: RDATA_O <= status_word;
                    fault_supervisor_pkg::OFF_IRQ_STAT: RDATA_O <= {25'h0, irq_stat_reg};
                    fault_supervisor_pkg::OFF_IRQ_EN: RDATA_O <= {25'h0, irq_en_reg};
                    default: RDATA_O <= 32'h0;
                endcase
            end else begin
                RDATA_O <= 32'h0;
            end
        end
    end

    // Checks on the trip, release and output relations
    property p_off_follows_fault;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        CE_I |=> CONV_OFF_O == $past(|fault_reg);
    endproperty
    a_off_follows_fault: assert property (p_off_follows_fault) else $error("Off cmd wrong"); // R06

    property p_latched_holds;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        (CE_I && fault_reg[fault_supervisor_pkg::P_OVT] && latch_reg[fault_supervisor_pkg::P_OVT]
            && !sw_clear) |=> fault_reg[fault_supervisor_pkg::P_OVT];
    endproperty
    a_latched_holds: assert property (p_latched_holds) else $error("Latched trip lost"); // R14

    property p_retry_release;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        (CE_I && $fell(fault_reg[fault_supervisor_pkg::P_OCP]) && !$past(sw_clear))
            |-> $past(retry_done) && !latch_reg[fault_supervisor_pkg::P_OCP];
    endproperty
    a_retry_release: assert property (p_retry_release) else $error("Trip freed early"); // R01

    property p_ovt_floor;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        raw[fault_supervisor_pkg::P_OVT] |-> VOUT_I > fault_supervisor_pkg::OVT_FLOOR_MV;
    endproperty
    a_ovt_floor: assert property (p_ovt_floor) else $error("OV trip under floor"); // R04

    property p_trk_armed;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        raw[fault_supervisor_pkg::P_TRK] |-> RAMP_UP_I && trk_en_reg
            && (17'(VOUT_I) > 17'(VTRACK_I) + 17'(fault_supervisor_pkg::TRK_BAND_MV)
            || 17'(VTRACK_I) > 17'(VOUT_I) + 17'(fault_supervisor_pkg::TRK_BAND_MV));
    endproperty
    a_trk_armed: assert property (p_trk_armed) else $error("Tracking not armed"); // R08

    property p_otp_restart;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        $fell(raw[fault_supervisor_pkg::P_OTP]) |-> TEMP_I <= fault_supervisor_pkg::OTP_RESTART_C;
    endproperty
    a_otp_restart: assert property (p_otp_restart) else $error("OT released hot"); // R07

    property p_warn_no_off;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        (CE_I && fault_reg == 5'h00) |=> !CONV_OFF_O;
    endproperty
    a_warn_no_off: assert property (p_warn_no_off) else $error("Off without a trip"); // R10

    property p_pg_follows;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        $rose(qual[fault_supervisor_pkg::Q_PG]) && CE_I |=> OUTPUT_IN_WINDOW_FLAG_O;
    endproperty
    a_pg_follows: assert property (p_pg_follows) else $error("Power good late"); // R12

    property p_irq_level;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        CE_I |=> IRQ_O == $past(|(irq_stat_reg & irq_en_reg));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong"); // R10

endmodule : fault_supervisor

// ===== verification/converter_model.sv
// Behavioural power stage: output follows the target while the converter runs
`timescale 1ns/1ps
module converter_model (
    // Clock and turn-off command
    input wire logic clk_i,
    input wire logic off_i,
    // Requested output and resulting sample
    input wire logic [15:0] target_i,
    output logic [15:0] vout_o
);
    // Output collapses to zero a cycle after turn-off, so an overvoltage condition goes away
    always_ff @(posedge clk_i) begin
        vout_o <= off_i ? 16'h0000 : target_i;
    end
endmodule : converter_model

// ===== verification/tb_top.sv
// Self-checking bench for the converter fault supervisor
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic ce = 1'b1;
    logic [31:0] rdata;
    logic [15:0] vout, target = 16'd1000, vset = 16'd1000, vtrack = 16'd1000;
    logic [15:0] iout = 16'd0, irated = 16'd100;
    logic signed [9:0] temp = 10'sd25;
    logic ramp = 1'b0;
    logic off, pg, irq;
    int error_cnt = 0;
    int tests_run = 0;
    int ticks = 0;
    // Short counts keep the run brief
    fault_supervisor #(.RETRY_CYCLES(50), .QUAL_CYCLES(8)) dut_u (
        .MCLK_I(mclk), .RSTN_I(rstn), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .VOUT_I(vout), .VSET_I(vset),
        .VTRACK_I(vtrack), .IOUT_I(iout), .IRATED_I(irated), .TEMP_I(temp),
        .RAMP_UP_I(ramp), .CONV_OFF_O(off), .OUTPUT_IN_WINDOW_FLAG_O(pg), .IRQ_O(irq));
    converter_model stage_u (.clk_i(mclk), .off_i(off), .target_i(target), .vout_o(vout));
    // Clock and hang guard
    initial begin
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        ticks <= ticks + 1;
        if (ticks == 6000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("Counts: %0d checks, %0d mismatches", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        @(negedge mclk);
        chk(rdata & m, e);
    endtask : rd_chk
    task automatic t_reset;
        cyc(1);
        chk(off, 1'b0);
        chk(pg, 1'b0);
        chk(irq, 1'b0);
        rd_chk(fault_supervisor_pkg::OFF_CTRL, 32'hffffffff, 32'h0);
        rd_chk(fault_supervisor_pkg::OFF_THRESH, 32'hffffffff, 32'h2a);
        rd_chk(8'h18, 32'hffffffff, 32'h0);
        $display("test reset done");
    endtask : t_reset
    // Window entered straight after reset, so power good is already up here
    task automatic t_window;
        cyc(4);
        chk(pg, 1'b1);
        cyc(10);
        chk(pg, 1'b1);
        target <= 16'd1120;
        cyc(4);
        chk(pg, 1'b1);
        cyc(10);
        chk(pg, 1'b0);
        target <= 16'd940;
        cyc(14);
        chk(pg, 1'b1);
        wr(fault_supervisor_pkg::OFF_THRESH, 32'h12a);
        cyc(14);
        chk(pg, 1'b0);
        wr(fault_supervisor_pkg::OFF_THRESH, 32'h2a);
        target <= 16'd1000;
        $display("test power good done");
    endtask : t_window
    task automatic t_overvolt;
        vset <= 16'd500;
        target <= 16'd900;
        cyc(20);
        chk(off, 1'b0);
        target <= 16'd1400;
        cyc(4);
        chk(off, 1'b0);
        cyc(8);
        chk(off, 1'b1);
        rd_chk(fault_supervisor_pkg::OFF_STATUS, 32'h122, 32'h122);
        target <= 16'd500;
        cyc(36);
        chk(off, 1'b1);
        cyc(25);
        chk(off, 1'b0);
        $display("test overvoltage retry done");
    endtask : t_overvolt
    task automatic t_latch;
        wr(fault_supervisor_pkg::OFF_CTRL, 32'h2);
        target <= 16'd1400;
        cyc(14);
        chk(off, 1'b1);
        target <= 16'd500;
        cyc(80);
        chk(off, 1'b1);
        wr(fault_supervisor_pkg::OFF_CTRL, 32'h42);
        cyc(4);
        chk(off, 1'b0);
        wr(fault_supervisor_pkg::OFF_CTRL, 32'h0);
        $display("test latching done");
    endtask : t_latch
    task automatic t_levels;
        vset <= 16'd1000;
        target <= 16'd1000;
        iout <= 16'd165;
        cyc(14);
        chk(off, 1'b0);
        wr(fault_supervisor_pkg::OFF_THRESH, 32'h20);
        iout <= 16'd65;
        cyc(14);
        chk(off, 1'b1);
        iout <= 16'd0;
        wr(fault_supervisor_pkg::OFF_THRESH, 32'h2a);
        cyc(70);
        target <= 16'd760;
        cyc(14);
        chk(off, 1'b0);
        wr(fault_supervisor_pkg::OFF_THRESH, 32'haa);
        cyc(14);
        chk(off, 1'b1);
        target <= 16'd1000;
        wr(fault_supervisor_pkg::OFF_THRESH, 32'h2a);
        cyc(70);
        chk(off, 1'b0);
        $display("test levels done");
    endtask : t_levels
    task automatic t_temp;
        temp <= 10'sd125;
        cyc(14);
        rd_chk(fault_supervisor_pkg::OFF_STATUS, 32'h60, 32'h40);
        temp <= 10'sd131;
        cyc(14);
        chk(off, 1'b1);
        temp <= 10'sd121;
        cyc(70);
        chk(off, 1'b1);
        temp <= 10'sd117;
        cyc(14);
        rd_chk(fault_supervisor_pkg::OFF_STATUS, 32'h60, 32'h0);
        $display("test temperature done");
    endtask : t_temp
    task automatic t_irq;
        wr(fault_supervisor_pkg::OFF_IRQ_CLR, 32'h7f);
        rd_chk(fault_supervisor_pkg::OFF_IRQ_STAT, 32'h7f, 32'h0);
        wr(fault_supervisor_pkg::OFF_IRQ_EN, 32'h2);
        target <= 16'd1400;
        cyc(14);
        chk(irq, 1'b1);
        rd_chk(fault_supervisor_pkg::OFF_IRQ_STAT, 32'h2, 32'h2);
        target <= 16'd1000;
        wr(fault_supervisor_pkg::OFF_IRQ_EN, 32'h0);
        cyc(2);
        chk(irq, 1'b0);
        wr(fault_supervisor_pkg::OFF_IRQ_EN, 32'h2);
        cyc(2);
        chk(irq, 1'b1);
        wr(fault_supervisor_pkg::OFF_IRQ_CLR, 32'h2);
        cyc(2);
        chk(irq, 1'b0);
        cyc(70);
        $display("test interrupt done");
    endtask : t_irq
    // Enable low freezes the filters, so an overvoltage cannot trip until it returns
    task automatic t_freeze;
        ce <= 1'b0;
        target <= 16'd1400;
        cyc(20);
        chk(off, 1'b0);
        ce <= 1'b1;
        cyc(14);
        chk(off, 1'b1);
        target <= 16'd1000;
        cyc(70);
        chk(off, 1'b0);
        $display("test clock enable done");
    endtask : t_freeze
    task automatic t_track;
        target <= 16'd1300;
        cyc(14);
        chk(off, 1'b0);
        wr(fault_supervisor_pkg::OFF_CTRL, 32'h20);
        cyc(14);
        chk(off, 1'b0);
        ramp <= 1'b1;
        cyc(14);
        chk(off, 1'b1);
        ramp <= 1'b0;
        target <= 16'd1000;
        $display("test tracking done");
    endtask : t_track
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_window();
        t_overvolt();
        t_latch();
        t_levels();
        t_temp();
        t_irq();
        t_freeze();
        t_track();
        complete_run();
    end
endmodule : tb_top
